// *** core_feature_config_words.sv ***
// core feature configuration words on system coprocessor register 16
//
// Behaviour
// - words three, four, five, seven sit at register 16 selects 3,4,5,7.
// - word three bit 3 always reads 1, shared device map present.
// - word three bits 2..1 always read zero.
// - word three bit 0 reads 0, no trace unit.
// - word four bit 31 reads 1 after reset, word five exists.
// - word four bits 30..24 always read zero.
// - word four bits 23..16 map scratch selects 0..7 of register 31.
// - scratch map is read-only and all zeros.
// - word four bits 15..0 reserved; software writes zero, reads zero.
// - word five bit 0 always reads 1, nested fault present.
// - word five bits 31..1 always read zero.
// - word seven bit 31 reads 1, interrupt releases wait.
// - word seven bits 30..0 always read zero.
// - word three bit 31 hardwired 1, word four exists.
`timescale 1ns/100ps
`include "cfgw_cfg.svh"
module core_feature_config_words (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire cfgw_pkg::cop_req_t req_in,
  output cfgw_pkg::cop_rsp_t rsp_out
);
  import cfgw_pkg::*;

  logic [31:0] word_three;
  logic [31:0] word_four_r;
  logic [31:0] word_five;
  logic [31:0] word_seven;
  logic reg_hit;
  logic sel_hit;
  logic [31:0] mux_data;
  cop_rsp_t rsp_r;

  // word three is pure constant wiring
  always_comb begin
    word_three = 32'h0000_0000;
    word_three[`CFGW_W3_NEXT_BIT] = 1'b1;
    word_three[`CFGW_W3_SDMM_BIT] = 1'b1;
    word_three[2:1] = 2'h0;
    word_three[`CFGW_W3_TRACE_BIT] = 1'b0;
  end

  // flags seen through the read path, not only the wiring
  chk_w3_next_bit: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_THREE) |=>
      (rsp_out.hit && rsp_out.rdata[`CFGW_W3_NEXT_BIT]))
    else $error("word three next-word flag missing");
  chk_w3_map_flag: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_THREE) |=>
      (rsp_out.hit && rsp_out.rdata[`CFGW_W3_SDMM_BIT]))
    else $error("word three device map flag missing");
  chk_w3_trace_off: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_THREE) |=>
      (rsp_out.rdata[`CFGW_W3_TRACE_BIT] == 1'b0))
    else $error("word three trace flag set");

  // word four is the one word taken at reset; a write cannot alter it
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      word_four_r <= `CFGW_W4_RESET;
    end else begin
      word_four_r <= `CFGW_W4_RESET;
      word_four_r[`CFGW_W4_KSCR_HI:`CFGW_W4_KSCR_LO] <=
        `CFGW_KSCR_MAP;
    end
  end

  // next-word flag, scratch map and reserved half as software sees them
  chk_w4_next_bit: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FOUR) |=>
      (rsp_out.hit && rsp_out.rdata[`CFGW_W4_NEXT_BIT]))
    else $error("word four next-word flag missing");
  chk_w4_unimpl_zero: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FOUR) |=>
      (rsp_out.rdata[30:24] == 7'h00))
    else $error("word four unimplemented bits set");
  chk_kscr_map_zero: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FOUR) |=>
      (rsp_out.rdata[`CFGW_W4_KSCR_HI:`CFGW_W4_KSCR_LO] == `CFGW_KSCR_MAP))
    else $error("scratch map not zero");
  chk_w4_reserved_zero: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FOUR) |=>
      (rsp_out.rdata[15:0] == 16'h0000))
    else $error("word four reserved bits not zero");
  chk_w4_reread_write: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.wr && reg_hit && req_in.sel == `CFGW_SEL_FOUR) ##1
      (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FOUR) |=>
      (rsp_out.hit && rsp_out.rdata == `CFGW_W4_RESET))
    else $error("write to word four stuck");

  // words five and seven carry a single set flag each
  always_comb begin
    word_five = 32'h0000_0000;
    word_five[`CFGW_W5_NF_BIT] = 1'b1;
  end

  always_comb begin
    word_seven = 32'h0000_0000;
    word_seven[`CFGW_W7_WII_BIT] = 1'b1;
  end

  // single flags and their empty remainders through a read
  chk_w5_nf_bit: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FIVE) |=>
      (rsp_out.hit && rsp_out.rdata[`CFGW_W5_NF_BIT]))
    else $error("word five nested fault flag missing");
  chk_w5_upper_zero: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FIVE) |=>
      (rsp_out.rdata[31:1] == 31'h0000_0000))
    else $error("word five upper bits set");
  chk_w7_wii_bit: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_SEVEN) |=>
      (rsp_out.hit && rsp_out.rdata[`CFGW_W7_WII_BIT]))
    else $error("word seven wait release flag missing");
  chk_w7_lower_zero: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_SEVEN) |=>
      (rsp_out.rdata[30:0] == 31'h0000_0000))
    else $error("word seven lower bits set");

  // writes decode the same way but nothing listens to their data
  assign reg_hit = (req_in.reg_num == `CFGW_REG_NUM);

  cfgw_word_mux #(
    .WORDS(4)
  ) u_mux (
    .sel_in(req_in.sel),
    .sel_map_in({`CFGW_SEL_SEVEN, `CFGW_SEL_FIVE,
                  `CFGW_SEL_FOUR, `CFGW_SEL_THREE}),
    .words_in({word_seven, word_five, word_four_r, word_three}),
    .hit_out(sel_hit),
    .data_out(mux_data)
  );

  // registered read answer, one cycle after the request
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      rsp_r <= '0;
    end else if (req_in.rd && reg_hit && sel_hit) begin
      rsp_r.hit <= 1'b1;
      rsp_r.rdata <= mux_data;
    end else begin
      rsp_r.hit <= 1'b0;
      rsp_r.rdata <= 32'h0000_0000;
    end
  end

  assign rsp_out = rsp_r;

  // words as read one cycle after the request; the word four register two cycles after a write
  chk_word_three_val: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_THREE) |=>
      (rsp_out.hit && rsp_out.rdata == `CFGW_W3_VALUE))
    else $error("word three read value wrong");
  chk_w3_low_bits: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_THREE) |=>
      (rsp_out.rdata[2:0] == 3'h0 && rsp_out.rdata[31]))
    else $error("word three low bits wrong");
  chk_word_four_val: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FOUR) |=>
      (rsp_out.rdata == `CFGW_W4_RESET))
    else $error("word four read value wrong");
  chk_w4_fields_zero: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FOUR) |=>
      (rsp_out.rdata[30:0] == 31'h0000_0000))
    else $error("word four fields not zero");
  chk_write_ignored: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.wr && reg_hit) |=> ##1 (word_four_r == `CFGW_W4_RESET))
    else $error("write altered word four");
  chk_word_five_val: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_FIVE) |=>
      (rsp_out.rdata == `CFGW_W5_VALUE))
    else $error("word five read value wrong");
  chk_word_seven_val: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && req_in.sel == `CFGW_SEL_SEVEN) |=>
      (rsp_out.rdata == `CFGW_W7_VALUE))
    else $error("word seven read value wrong");
  chk_unmapped_miss: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && (!reg_hit || req_in.sel < 3'h3 ||
      req_in.sel == 3'h6)) |=>
      (!rsp_out.hit && rsp_out.rdata == 32'h0000_0000))
    else $error("unmapped select answered");

  // the answer stands one cycle and only after a mapped read
  chk_mapped_hit: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    (req_in.rd && reg_hit && (req_in.sel == `CFGW_SEL_THREE ||
      req_in.sel == `CFGW_SEL_FOUR || req_in.sel == `CFGW_SEL_FIVE ||
      req_in.sel == `CFGW_SEL_SEVEN)) |=> rsp_out.hit)
    else $error("mapped read not answered");
  chk_no_read_silent: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !req_in.rd |=> (!rsp_out.hit && rsp_out.rdata == 32'h0000_0000))
    else $error("answer without a read");
  chk_idle_data_zero: assert property (
    @(posedge core_clk_in) disable iff (!reset_n_in)
    !rsp_out.hit |-> (rsp_out.rdata == 32'h0000_0000))
    else $error("data shown without a hit");
  chk_reset_clears: assert property (
    @(posedge core_clk_in)
    !reset_n_in |=> (!rsp_out.hit && rsp_out.rdata == 32'h0000_0000))
    else $error("answer not cleared by reset");
endmodule

// *** cfgw_cfg.svh ***
// constants for the core feature configuration words
`ifndef CFGW_CFG_SVH
`define CFGW_CFG_SVH
`define CFGW_REG_NUM 5'h10
`define CFGW_SEL_THREE 3'h3
`define CFGW_SEL_FOUR 3'h4
`define CFGW_SEL_FIVE 3'h5
`define CFGW_SEL_SEVEN 3'h7
`define CFGW_W3_NEXT_BIT 31
`define CFGW_W3_SDMM_BIT 3
`define CFGW_W3_TRACE_BIT 0
`define CFGW_W4_NEXT_BIT 31
`define CFGW_W4_KSCR_LO 16
`define CFGW_W4_KSCR_HI 23
`define CFGW_W5_NF_BIT 0
`define CFGW_W7_WII_BIT 31
`define CFGW_W3_VALUE 32'h8000_0008
`define CFGW_W4_RESET 32'h8000_0000
`define CFGW_W5_VALUE 32'h0000_0001
`define CFGW_W7_VALUE 32'h8000_0000
`define CFGW_KSCR_MAP 8'h00
`endif

// *** cfgw_pkg.sv ***
// types for the core feature configuration words
package cfgw_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] reg_num;
    logic [2:0] sel;
    logic [31:0] wdata;
  } cop_req_t;
  typedef struct packed {
    logic hit;
    logic [31:0] rdata;
  } cop_rsp_t;
endpackage

// *** cfgw_word_mux.sv ***
// read mux choosing one configuration word by select
`timescale 1ns/100ps
module cfgw_word_mux #(
  parameter int WORDS = 4
) (
  input wire logic [2:0] sel_in,
  input wire logic [WORDS*3-1:0] sel_map_in,
  input wire logic [WORDS*32-1:0] words_in,
  output logic hit_out,
  output logic [31:0] data_out
);
  // one 3-bit select per word; beyond eight they cannot be told apart
  if (WORDS < 1 || WORDS > 8) begin : g_bad_words
    $error("cfgw_word_mux: WORDS out of range");
  end
  logic [WORDS-1:0] match;
  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_match
      assign match[g] = (sel_map_in[g*3 +: 3] == sel_in);
    end
  endgenerate
  always_comb begin
    hit_out = |match;
    data_out = 32'h0000_0000;
    for (int i = 0; i < WORDS; i++) begin
      if (match[i]) begin
        data_out = words_in[i*32 +: 32];
      end
    end
  end
endmodule

// *** tb.sv ***
// self-checking bench for the core feature configuration words
`timescale 1ns/100ps
module tb;
  import cfgw_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  cop_req_t req = '0;
  cop_rsp_t rsp;
  cop_rsp_t exp_rsp = '0;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 32'h9AC74143;
  bit rst;
  bit idle;

  core_feature_config_words u_core_feature_config_words (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .req_in(req),
    .rsp_out(rsp)
  );

  initial begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic check(input cop_rsp_t seen, input cop_rsp_t want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("mismatch at %0t: rsp %h want %h", $time, seen, want);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // answer expected one cycle after a request, built bit by bit
  function automatic cop_rsp_t model(input cop_req_t r);
    cop_rsp_t m;
    m = '0;
    if (r.rd && r.reg_num == 5'h10) begin
      m.hit = 1'b1;
      case (r.sel)
        3'h3: m.rdata = (32'h1 << 31) | (32'h1 << 3);
        3'h4: m.rdata = 32'h1 << 31;
        3'h5: m.rdata = 32'h1;
        3'h7: m.rdata = 32'h1 << 31;
        default: m.hit = 1'b0;
      endcase
    end
    return m;
  endfunction

  // writes mixed in; half the requests aim at register 16
  task automatic random_req(output cop_req_t r);
    r.rd = 1'($random(seed));
    r.wr = ~r.rd & 1'($random(seed));
    r.reg_num = ($random(seed) & 1) ? 5'h10 : 5'($random(seed));
    r.sel = 3'($random(seed));
    r.wdata = $random(seed) & 32'hFFFF_0000;
  endtask

  initial begin
    for (int i = 0; i < 600; i++) begin
      @(posedge core_clk_in);
      #1;
      if (i > 0) begin
        check(rsp, exp_rsp);
      end
      // no request in reset nor in the cycle that releases it
      rst = (i < 5) || (i >= 300 && i < 303);
      idle = rst || !reset_n_in;
      reset_n_in = !rst;
      if (idle) begin
        req = '0;
      end else if (i >= 400 && i < 440) begin
        // word four written then read back, cycle after cycle
        req = '{rd: i[0], wr: !i[0], reg_num: 5'h10, sel: 3'h4,
                wdata: 32'($random(seed)) & 32'hFFFF_0000};
      end else begin
        random_req(req);
      end
      exp_rsp = model(req);
    end
    end_of_test();
  end

  // run needs about 600 cycles; a hang is cut well beyond that
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      end_of_test();
    end
  end
endmodule
